// ### dcf_pkg.sv
// What this block does
// R1 - Empty released one read cycle after write
// R2 - Latency counted only from the empty state
// R3 - Write needs both write enables active
// R4 - Almost-full low at depth minus m words
// R5 - Almost-full updated on the write clock
// R6 - Write at almost-full edge leaves Full-(m-1)
// R7 - Almost-empty updated on the read clock
// R8 - Read at almost-empty edge leaves Empty+(n-1)
// R9 - Load pin low at reset selects offsets
// R10 - Second read enable may be tied active
// R11 - Width expansion combines empty, full flags
// R12 - Pin high at reset: second enable, defaults
// R13 - Depth expansion steers one enable per port
// R14 - Offsets default to seven words
// R15 - Empty low when read equals write pointer
// R16 - Two independent channels, no interaction
package dcf_pkg;

  // ****************************************
  // Array shape
  // ****************************************
  localparam int NCH       = 2;
  localparam int DW        = 9;
  localparam int DEPTH_DEF = 256;
  localparam int DEPTH_MIN = 256;
  localparam int DEPTH_MAX = 8192;
  localparam int OFS_W     = 16;

  localparam logic [OFS_W-1:0] OFS_DEF = 16'h0007;

  // ****************************************
  // Offset register sequence
  // ****************************************
  localparam logic [1:0] SEQ_E_LO = 2'h0;
  localparam logic [1:0] SEQ_E_HI = 2'h1;
  localparam logic [1:0] SEQ_F_LO = 2'h2;
  localparam logic [1:0] SEQ_F_HI = 2'h3;

  // ****************************************
  // Controller registers (byte addresses)
  // ****************************************
  localparam int AVS_AW = 5;

  localparam logic [AVS_AW-1:0] REG_CTRL   = 5'h00;
  localparam logic [AVS_AW-1:0] REG_WDATA0 = 5'h04;
  localparam logic [AVS_AW-1:0] REG_WDATA1 = 5'h08;
  localparam logic [AVS_AW-1:0] REG_RDATA0 = 5'h0c;
  localparam logic [AVS_AW-1:0] REG_RDATA1 = 5'h10;
  localparam logic [AVS_AW-1:0] REG_FLAGS  = 5'h14;
  localparam logic [AVS_AW-1:0] REG_ISTAT  = 5'h18;
  localparam logic [AVS_AW-1:0] REG_IMASK  = 5'h1c;

  localparam logic [NCH-1:0] CTRL_RST = 2'h0;

  // Flag layout, four bits per channel at 4*ch
  localparam int FL_EMPTY = 0;
  localparam int FL_FULL  = 1;
  localparam int FL_AE    = 2;
  localparam int FL_AF    = 3;
  localparam int FL_W     = 4 * NCH;

  localparam logic [FL_W-1:0] IMASK_RST = 8'h00;

endpackage : dcf_pkg

// ### dcf_if.sv
`timescale 1ns/1ps
interface dcf_if;
  import dcf_pkg::*;

  logic [NCH-1:0]         write_enable_primary_n;
  logic [NCH-1:0]         second_write_enable_or_offset_load_n;
  logic [NCH-1:0]         read_enable_primary_n;
  logic [NCH-1:0]         read_enable_secondary_n;
  logic [NCH-1:0][DW-1:0] wr_data;
  logic [NCH-1:0][DW-1:0] rd_data;
  logic [NCH-1:0]         empty_flag_n;
  logic [NCH-1:0]         full_flag_n;
  logic [NCH-1:0]         almost_empty_flag_n;
  logic [NCH-1:0]         almost_full_flag_n;

  modport dev (
    input  write_enable_primary_n,
    input  second_write_enable_or_offset_load_n,
    input  read_enable_primary_n,
    input  read_enable_secondary_n,
    input  wr_data,
    output rd_data,
    output empty_flag_n,
    output full_flag_n,
    output almost_empty_flag_n,
    output almost_full_flag_n
  );

  modport host (
    output write_enable_primary_n,
    output second_write_enable_or_offset_load_n,
    output read_enable_primary_n,
    output read_enable_secondary_n,
    output wr_data,
    input  rd_data,
    input  empty_flag_n,
    input  full_flag_n,
    input  almost_empty_flag_n,
    input  almost_full_flag_n
  );

endinterface : dcf_if

// ### dcf_fifo_dev.sv
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module dcf_fifo_dev
  import dcf_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  dcf_if.dev       pins
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX || (2 ** AW) != DEPTH) begin : g_bad_depth
    $error("dcf_fifo_dev: DEPTH must be a power of two from 256 to 8192");
  end

  // ****************************************
  // Helpers
  // ****************************************
  // Almost-full when occupancy reaches depth minus m
  function automatic logic af_hit(input logic [CW-1:0] cnt, input logic [OFS_W-1:0] m);
    logic [OFS_W:0] lim;
    lim = (OFS_W + 1)'(DEPTH) - {1'b0, m};
    af_hit = {{(OFS_W + 1 - CW){1'b0}}, cnt} >= lim;
  endfunction : af_hit

  // Almost-empty while occupancy is n words or fewer
  function automatic logic ae_hit(input logic [CW-1:0] cnt, input logic [OFS_W-1:0] n);
    ae_hit = {{(OFS_W + 1 - CW){1'b0}}, cnt} <= {1'b0, n};
  endfunction : ae_hit

  // Offset byte selected by the load sequence
  function automatic logic [7:0] ofs_byte(input logic [1:0] seq,
                                          input logic [OFS_W-1:0] e,
                                          input logic [OFS_W-1:0] f);
    ofs_byte = seq[1] ? (seq[0] ? f[15:8] : f[7:0]) : (seq[0] ? e[15:8] : e[7:0]);
  endfunction : ofs_byte

  // ****************************************
  // Channels
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch  // R16
    logic [DW-1:0]    mem_ff [DEPTH];
    logic [AW-1:0]    wp_ff;
    logic [AW-1:0]    rp_ff;
    logic [CW-1:0]    cnt_ff;
    logic [CW-1:0]    nxt_cnt;
    logic [OFS_W-1:0] eofs_ff;
    logic [OFS_W-1:0] fofs_ff;
    logic [1:0]       wseq_ff;
    logic [1:0]       rseq_ff;
    logic             depth_mode_ff;
    logic             strap_done_ff;
    logic [DW-1:0]    q_ff;
    logic             empty_n_ff;
    logic             full_n_ff;
    logic             ae_n_ff;
    logic             af_n_ff;
    logic             write_enable_primary;
    logic             pin2_low;
    logic             ren_both;
    logic             ofs_sel;
    logic             wr_ok;
    logic             rd_ok;
    logic             ofs_wr;
    logic             ofs_rd;

    // ****************************************
    // Enable decode
    // ****************************************
    assign write_enable_primary     = !pins.write_enable_primary_n[c];
    assign pin2_low = !pins.second_write_enable_or_offset_load_n[c];
    // A tied-active second read enable leaves the first one in charge
    assign ren_both = !pins.read_enable_primary_n[c] && !pins.read_enable_secondary_n[c];  // R10
    assign ofs_sel  = strap_done_ff && !depth_mode_ff && pin2_low;  // R9

    assign wr_ok  = strap_done_ff && write_enable_primary && (depth_mode_ff ? pin2_low : !pin2_low)
                    && (cnt_ff != FULL_CNT);  // R3 R12
    // An empty array refuses reads: pointers are equal
    assign rd_ok  = strap_done_ff && ren_both && !ofs_sel && (cnt_ff != '0);  // R15
    assign ofs_wr = ofs_sel && write_enable_primary;  // R9
    assign ofs_rd = ofs_sel && ren_both && !write_enable_primary;

    // A write and a read on one edge leave the count as it is
    always_comb begin
      nxt_cnt = cnt_ff;
      if (wr_ok && !rd_ok) begin
        nxt_cnt = cnt_ff + 1'b1;
      end else if (rd_ok && !wr_ok) begin
        nxt_cnt = cnt_ff - 1'b1;
      end
    end

    // ****************************************
    // Mode strap
    // ****************************************
    // Mode is taken from the load pin at the first edge after reset
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        depth_mode_ff <= 1'b0;
        strap_done_ff <= 1'b0;
      end else if (ce && !strap_done_ff) begin
        depth_mode_ff <= !pin2_low;  // R9 R12
        strap_done_ff <= 1'b1;
      end
    end

    // ****************************************
    // Storage
    // ****************************************
    // The array has no reset: a word is only read after it was written
    always_ff @(posedge mclk) begin
      if (ce && wr_ok) begin
        mem_ff[wp_ff] <= pins.wr_data[c];
      end
    end

    // ****************************************
    // Pointers and count
    // ****************************************
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        wp_ff  <= '0;
        rp_ff  <= '0;
        cnt_ff <= '0;
      end else if (ce) begin
        if (wr_ok) begin
          wp_ff <= wp_ff + 1'b1;
        end
        if (rd_ok) begin
          rp_ff <= rp_ff + 1'b1;
        end
        cnt_ff <= nxt_cnt;
      end
    end

    // ****************************************
    // Offset registers
    // ****************************************
    // Offsets stay at their defaults unless loaded in single-device mode
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        eofs_ff <= OFS_DEF;  // R14
        fofs_ff <= OFS_DEF;  // R14
        wseq_ff <= SEQ_E_LO;
      end else if (ce) begin
        if (ofs_wr) begin
          unique case (wseq_ff)
            SEQ_E_LO: eofs_ff[7:0]  <= pins.wr_data[c][7:0];
            SEQ_E_HI: eofs_ff[15:8] <= pins.wr_data[c][7:0];
            SEQ_F_LO: fofs_ff[7:0]  <= pins.wr_data[c][7:0];
            SEQ_F_HI: fofs_ff[15:8] <= pins.wr_data[c][7:0];
          endcase
          wseq_ff <= wseq_ff + 1'b1;
        end
      end
    end

    // ****************************************
    // Output word
    // ****************************************
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        rseq_ff <= SEQ_E_LO;
        q_ff    <= '0;
      end else if (ce) begin
        if (rd_ok) begin
          q_ff <= mem_ff[rp_ff];
        end else if (ofs_rd) begin
          q_ff    <= {{(DW - 8){1'b0}}, ofs_byte(rseq_ff, eofs_ff, fofs_ff)};
          rseq_ff <= rseq_ff + 1'b1;
        end
      end
    end

    // ****************************************
    // Flags
    // ****************************************
    // Flags follow the count one edge late: a word written into an empty
    // array releases the empty flag one cycle after its write edge. Internal
    // gating uses the live count, so the lag cannot overrun the array.
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        empty_n_ff <= 1'b0;
        full_n_ff  <= 1'b1;
        ae_n_ff    <= 1'b0;
        af_n_ff    <= 1'b1;
      end else if (ce) begin
        empty_n_ff <= (cnt_ff != '0);  // R1 R2 R15
        full_n_ff  <= (cnt_ff != FULL_CNT);
        af_n_ff    <= !af_hit(cnt_ff, fofs_ff);  // R4 R5 R6
        ae_n_ff    <= !ae_hit(cnt_ff, eofs_ff);  // R7 R8
      end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    assign pins.rd_data[c]             = q_ff;
    assign pins.empty_flag_n[c]        = empty_n_ff;
    assign pins.full_flag_n[c]         = full_n_ff;
    assign pins.almost_empty_flag_n[c] = ae_n_ff;
    assign pins.almost_full_flag_n[c]  = af_n_ff;
  end

endmodule : dcf_fifo_dev

// ### dcf_host.sv
`timescale 1ns/1ps
module dcf_host
  import dcf_pkg::*;
#(
  parameter logic [NCH-1:0] DEPTH_MODE = 2'h0
)
(
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic [AVS_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  dcf_if.host                    pins
);

  typedef enum logic [1:0] {ST_IDLE, ST_PIN, ST_SETTLE, ST_ACK} dcf_st_t;

  dcf_st_t          st_ff;
  logic [NCH-1:0]   ctrl_ff;
  logic [FL_W-1:0]  istat_ff;
  logic [FL_W-1:0]  imask_ff;
  logic [FL_W-1:0]  flags_prev_ff;
  logic [FL_W-1:0]  flags;
  logic [FL_W-1:0]  nxt_istat;
  logic [NCH-1:0]   wen_ff;
  logic [NCH-1:0]   ld_ff;
  logic [NCH-1:0]   ren_ff;
  logic [DW-1:0]    wdata_ff;
  logic [31:0]      rdata_ff;
  logic             wait_ff;
  logic             irq_ff;
  logic             req;
  logic             ch;
  logic             is_wdata;
  logic             is_rdata;

  assign req      = avs_read || avs_write;
  assign is_wdata = avs_write && (avs_address == REG_WDATA0 || avs_address == REG_WDATA1);
  assign is_rdata = avs_read && (avs_address == REG_RDATA0 || avs_address == REG_RDATA1);
  assign ch       = (avs_address == REG_WDATA1) || (avs_address == REG_RDATA1);

  for (genvar c = 0; c < NCH; c++) begin : g_fl  // R11
    assign flags[4*c+FL_EMPTY] = pins.empty_flag_n[c];
    assign flags[4*c+FL_FULL]  = pins.full_flag_n[c];
    assign flags[4*c+FL_AE]    = pins.almost_empty_flag_n[c];
    assign flags[4*c+FL_AF]    = pins.almost_full_flag_n[c];
  end

  // ****************************************
  // Bus sequencing
  // ****************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff    <= ST_IDLE;
      wait_ff  <= 1'b1;
      wen_ff   <= '0;
      ren_ff   <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
    end else if (ce) begin
      unique case (st_ff)
        ST_IDLE: begin
          if (req) begin
            if (is_wdata || is_rdata) begin
              wen_ff[ch] <= is_wdata;
              ren_ff[ch] <= is_rdata;
              wdata_ff   <= avs_writedata[DW-1:0];
              st_ff      <= is_rdata ? ST_SETTLE : ST_PIN;
            end else begin
              unique case (avs_address)
                REG_CTRL:  rdata_ff <= {{(32 - NCH){1'b0}}, ctrl_ff};
                REG_FLAGS: rdata_ff <= {{(32 - FL_W){1'b0}}, flags};
                REG_ISTAT: rdata_ff <= {{(32 - FL_W){1'b0}}, istat_ff};
                REG_IMASK: rdata_ff <= {{(32 - FL_W){1'b0}}, imask_ff};
                default:   rdata_ff <= '0;
              endcase
              wait_ff <= 1'b0;
              st_ff   <= ST_ACK;
            end
          end
        end
        ST_SETTLE: begin
          // Read data appear one edge after the read strobe
          ren_ff <= '0;
          st_ff  <= ST_PIN;
        end
        ST_PIN: begin
          wen_ff   <= '0;
          rdata_ff <= {{(32 - DW){1'b0}}, pins.rd_data[ch]};
          wait_ff  <= 1'b0;
          st_ff    <= ST_ACK;
        end
        ST_ACK: begin
          wait_ff <= 1'b1;
          st_ff   <= ST_IDLE;
        end
      endcase
    end
  end

  // Depth mode holds the pin high in reset and uses it as a second enable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ld_ff <= DEPTH_MODE;  // R9 R12
    end else if (ce) begin
      for (int c = 0; c < NCH; c++) begin
        if (DEPTH_MODE[c]) begin
          ld_ff[c] <= !(st_ff == ST_IDLE && is_wdata && ch == c[0]);  // R13
        end else begin
          ld_ff[c] <= !ctrl_ff[c];
        end
      end
    end
  end

  // ****************************************
  // Registers and interrupt
  // ****************************************
  always_comb begin
    nxt_istat = istat_ff | (flags_prev_ff & ~flags);
    if (st_ff == ST_ACK && avs_write && avs_address == REG_ISTAT) begin
      // A flag that falls in the clearing cycle survives
      nxt_istat = (istat_ff & ~avs_writedata[FL_W-1:0]) | (flags_prev_ff & ~flags);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff       <= CTRL_RST;
      imask_ff      <= IMASK_RST;
      istat_ff      <= '0;
      flags_prev_ff <= '0;
      irq_ff        <= 1'b0;
    end else if (ce) begin
      if (st_ff == ST_ACK && avs_write && avs_address == REG_CTRL) begin
        ctrl_ff <= avs_writedata[NCH-1:0];
      end
      if (st_ff == ST_ACK && avs_write && avs_address == REG_IMASK) begin
        imask_ff <= avs_writedata[FL_W-1:0];
      end
      flags_prev_ff <= flags;
      istat_ff      <= nxt_istat;
      irq_ff        <= |(nxt_istat & imask_ff);
    end
  end

  assign pins.write_enable_primary_n               = ~wen_ff;  // R3
  assign pins.second_write_enable_or_offset_load_n = ld_ff;
  assign pins.read_enable_primary_n                = ~ren_ff;
  assign pins.read_enable_secondary_n              = ~ren_ff;
  for (genvar c = 0; c < NCH; c++) begin : g_wd
    assign pins.wr_data[c] = wdata_ff;
  end
  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq             = irq_ff;

endmodule : dcf_host

// ### dcf_assertions.sv
`timescale 1ns/1ps
module dcf_assertions
  import dcf_pkg::*;
#(
  parameter int             DEPTH = DEPTH_DEF,
  parameter logic [NCH-1:0] MODE  = 2'h0,
  parameter int             N0    = 7,
  parameter int             M0    = 7
)
(
  input wire logic                   mclk,
  input wire logic                   rstn,
  input wire logic [NCH-1:0]         write_enable_primary_n,
  input wire logic [NCH-1:0]         second_write_enable_or_offset_load_n,
  input wire logic [NCH-1:0]         read_enable_primary_n,
  input wire logic [NCH-1:0]         read_enable_secondary_n,
  input wire logic [NCH-1:0][DW-1:0] rd_data,
  input wire logic [NCH-1:0]         empty_flag_n,
  input wire logic [NCH-1:0]         full_flag_n,
  input wire logic [NCH-1:0]         almost_empty_flag_n,
  input wire logic [NCH-1:0]         almost_full_flag_n
);
  // ****************************************
  // Occupancy model, clock enable held high
  // ****************************************
  logic [NCH-1:0][13:0] cnt_ff;
  logic [NCH-1:0]       wr_go;
  logic [NCH-1:0]       rd_go;
  logic [NCH-1:0]       exp_e;
  logic [NCH-1:0]       exp_f;
  logic [NCH-1:0]       exp_ae;
  logic [NCH-1:0]       exp_af;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      wr_go[c]  = !write_enable_primary_n[c] && (second_write_enable_or_offset_load_n[c] ^ MODE[c])
                  && cnt_ff[c] < 14'(DEPTH);
      // Offset access in load mode must not consume data
      rd_go[c]  = !read_enable_primary_n[c] && !read_enable_secondary_n[c] && cnt_ff[c] != 14'h0
                  && (MODE[c] || second_write_enable_or_offset_load_n[c]);
      exp_e[c]  = cnt_ff[c] != 14'h0;
      exp_f[c]  = cnt_ff[c] != 14'(DEPTH);
      exp_ae[c] = cnt_ff[c] > (c == 0 ? 14'(N0) : 14'(OFS_DEF));
      exp_af[c] = cnt_ff[c] < (c == 0 ? 14'(DEPTH - M0) : 14'(DEPTH) - 14'(OFS_DEF));
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        cnt_ff[c] <= cnt_ff[c] + 14'(wr_go[c]) - 14'(rd_go[c]);
      end
    end
  end

  // ****************************************
  // Flag and data checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  chk_empty_count: assert property (empty_flag_n == $past(exp_e))
    else $error("empty flag does not follow occupancy");
  chk_full_count: assert property (full_flag_n == $past(exp_f))
    else $error("full flag does not follow occupancy");
  chk_almost_full: assert property (almost_full_flag_n == $past(exp_af))
    else $error("almost-full flag off its threshold");
  chk_almost_empty: assert property (almost_empty_flag_n == $past(exp_ae))
    else $error("almost-empty flag off its threshold");
  chk_first_word: assert property (!empty_flag_n[0] && wr_go[0] |-> ##[1:2] empty_flag_n[0])
    else $error("empty flag not released after first word");
  chk_load_gate: assert property ($rose(empty_flag_n[0]) |->
    !$past(write_enable_primary_n[0], 2) && $past(second_write_enable_or_offset_load_n[0], 2))
    else $error("channel 0 filled without a data write");
  chk_depth_gate: assert property ($rose(empty_flag_n[1]) |->
    !$past(write_enable_primary_n[1], 2) && !$past(second_write_enable_or_offset_load_n[1], 2))
    else $error("channel 1 filled without both enables");
  chk_empty_cause: assert property ($fell(empty_flag_n[0]) |-> !$past(read_enable_primary_n[0], 2))
    else $error("channel 0 emptied without a read");
  chk_data_hold: assert property (&(read_enable_primary_n | read_enable_secondary_n) |=> $stable(rd_data))
    else $error("read data moved without a read");

endmodule : dcf_assertions

// ### dual_clock_fifo_flag_timing_tb.sv
`timescale 1ns/1ps
module dual_clock_fifo_flag_timing_tb
  import dcf_pkg::*;
;
  localparam int             DEPTH = 256;
  localparam logic [NCH-1:0] MODE  = 2'h2;

  logic              mclk;
  logic              rstn;
  logic              ce;
  logic [AVS_AW-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              irq;
  int                n_fail     = 0;
  int                num_checks = 0;
  int                cnt [NCH]  = '{0, 0};
  int                ofs_n [NCH] = '{3, 7};
  int                ofs_m [NCH] = '{5, 7};
  logic [7:0]        ofs [4]    = '{8'h03, 8'h00, 8'h05, 8'h00};
  logic [DW-1:0]     q [NCH][$];
  logic [DW-1:0]     last [NCH] = '{9'h0, 9'h0};
  logic [FL_W-1:0]   ist_exp;
  logic [FL_W-1:0]   fl_old;

  dcf_if pins ();

  dcf_fifo_dev #(.DEPTH(DEPTH)) i_dcf_fifo_dev (.mclk(mclk), .rstn(rstn), .ce(ce), .pins(pins.dev));

  dcf_host #(.DEPTH_MODE(MODE)) i_dcf_host (.mclk(mclk), .rstn(rstn), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .pins(pins.host));

  dcf_assertions #(.DEPTH(DEPTH), .MODE(MODE), .N0(3), .M0(5)) i_dcf_assertions (.mclk(mclk), .rstn(rstn),
    .write_enable_primary_n(pins.write_enable_primary_n),
    .second_write_enable_or_offset_load_n(pins.second_write_enable_or_offset_load_n),
    .read_enable_primary_n(pins.read_enable_primary_n), .read_enable_secondary_n(pins.read_enable_secondary_n),
    .rd_data(pins.rd_data), .empty_flag_n(pins.empty_flag_n), .full_flag_n(pins.full_flag_n),
    .almost_empty_flag_n(pins.almost_empty_flag_n), .almost_full_flag_n(pins.almost_full_flag_n));

  // ****************************************
  // Bus and model helpers
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic av(input logic wr, input logic [AVS_AW-1:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 20)
      chk(32'h0, 32'h1);
  endtask : av

  function automatic logic [FL_W-1:0] flags_of();
    logic [FL_W-1:0] f;
    for (int c = 0; c < NCH; c++) begin
      f[4*c+FL_EMPTY] = cnt[c] != 0;
      f[4*c+FL_FULL]  = cnt[c] != DEPTH;
      f[4*c+FL_AE]    = cnt[c] > ofs_n[c];
      f[4*c+FL_AF]    = cnt[c] < DEPTH - ofs_m[c];
    end
    return f;
  endfunction : flags_of

  // Every data op is followed by a flag read, so each threshold crossing is seen
  task automatic op(input int c, input logic wr, input logic [DW-1:0] d);
    logic [31:0]     r;
    logic [FL_W-1:0] f;
    if (wr) begin
      av(1'b1, c ? REG_WDATA1 : REG_WDATA0, {23'h0, d}, r);
      if (cnt[c] < DEPTH) begin
        q[c].push_back(d);
        cnt[c]++;
      end
    end else begin
      av(1'b0, c ? REG_RDATA1 : REG_RDATA0, 32'h0, r);
      if (cnt[c] > 0) begin
        last[c] = q[c].pop_front();
        cnt[c]--;
      end
      chk(r, {23'h0, last[c]});
    end
    f = flags_of();
    ist_exp |= fl_old & ~f;
    fl_old = f;
    av(1'b0, REG_FLAGS, 32'h0, r);
    chk(r, 32'(f));
  endtask : op

  task final_report();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // ****************************************
  // Clock, watchdog and test sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    final_report();
  end

  initial begin
    int          c;
    logic        w;
    logic [31:0] r;
    rstn          = 1'b0;
    ce            = 1'b1;
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    ist_exp       = '0;
    fl_old        = flags_of();
    void'($urandom(32'h1d0f));
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    av(1'b0, REG_FLAGS, 32'h0, r);
    chk(r, 32'h0000_00aa);
    av(1'b0, REG_CTRL, 32'h0, r);
    chk(r, 32'(CTRL_RST));
    av(1'b0, REG_IMASK, 32'h0, r);
    chk(r, 32'(IMASK_RST));
    av(1'b1, 5'h1e, 32'hffff_ffff, r);
    av(1'b0, 5'h1e, 32'h0, r);
    chk(r, 32'h0);
    $display("test registers done");
    // A word is kept in channel 0 so later reads show the offset accesses left it in place
    op(0, 1'b1, 9'h0a5);
    av(1'b1, REG_CTRL, 32'h1, r);
    foreach (ofs[i]) av(1'b1, REG_WDATA0, {24'h0, ofs[i]}, r);
    foreach (ofs[i]) begin
      av(1'b0, REG_RDATA0, 32'h0, r);
      chk(r, {24'h0, ofs[i]});
    end
    last[0] = {1'b0, ofs[3]};
    av(1'b1, REG_CTRL, 32'h0, r);
    $display("test offsets done");
    for (int i = 0; i < 80; i++) begin
      c = $urandom_range(1);
      w = ($urandom_range(2) != 0) || cnt[c] == 0;
      op(c, w, 9'($urandom));
    end
    $display("test random traffic done");
    for (int i = 0; i <= DEPTH; i++) op(1, 1'b1, 9'($urandom));
    for (int i = 0; i <= DEPTH; i++) op(1, 1'b0, 9'h0);
    $display("test fill and drain done");
    av(1'b0, REG_ISTAT, 32'h0, r);
    chk(r, 32'(ist_exp));
    chk(32'(irq), 32'h0);
    av(1'b1, REG_IMASK, 32'hff, r);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h1);
    av(1'b1, REG_ISTAT, 32'hff, r);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0);
    av(1'b0, REG_ISTAT, 32'h0, r);
    chk(r, 32'h0);
    $display("test interrupts done");
    // A frozen host must keep its wait state until the enable returns
    @(posedge mclk);
    ce          <= 1'b0;
    avs_address <= REG_FLAGS;
    avs_read    <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(32'(avs_waitrequest), 32'h1);
    ce <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    chk(r, 32'(flags_of()));
    $display("test clock enable done");
    final_report();
  end

endmodule : dual_clock_fifo_flag_timing_tb
